// File: src/spss_pkg.sv
// Package of states, encodings and timing constants for the power state sequencer
package spss_pkg;
	// Controller states, one-hot
	typedef enum logic [8:0] {
		SPSS_C0 = 9'h001,
		SPSS_C1 = 9'h002,
		SPSS_ENTER = 9'h004,
		SPSS_S1 = 9'h008,
		SPSS_S3 = 9'h010,
		SPSS_S4 = 9'h020,
		SPSS_S5 = 9'h040,
		SPSS_G3 = 9'h080,
		SPSS_BOOT = 9'h100
	} spss_state_t;
	// Requested sleep type
	localparam logic [1:0] SPSS_SLP_S1 = 2'h0;
	localparam logic [1:0] SPSS_SLP_S3 = 2'h1;
	localparam logic [1:0] SPSS_SLP_S4 = 2'h2;
	localparam logic [1:0] SPSS_SLP_S5 = 2'h3;
	// Reported state codes
	localparam logic [3:0] SPSS_CODE_C0 = 4'h0;
	localparam logic [3:0] SPSS_CODE_C1 = 4'h1;
	localparam logic [3:0] SPSS_CODE_S1 = 4'h2;
	localparam logic [3:0] SPSS_CODE_S3 = 4'h3;
	localparam logic [3:0] SPSS_CODE_S4 = 4'h4;
	localparam logic [3:0] SPSS_CODE_S5 = 4'h5;
	localparam logic [3:0] SPSS_CODE_G3 = 4'h6;
	// Sleep delay after first stop-grant: PCI clocks
	localparam int SPSS_SLP_DLY_PCI = 60;
	localparam int SPSS_PCI_MHZ = 33;
	localparam int SPSS_CLK_MHZ = 125;
	// Least time rounds up to whole core clocks
	localparam int SPSS_SLP_DLY_CYC =
		(SPSS_SLP_DLY_PCI * SPSS_CLK_MHZ + SPSS_PCI_MHZ - 1) / SPSS_PCI_MHZ;
	localparam int SPSS_CNT_W = 8;
	localparam logic [7:0] SPSS_SLP_DLY = 8'(SPSS_SLP_DLY_CYC);
	// Throttle duty: period and stop-clock portion in core clocks
	localparam int SPSS_THR_W = 4;
	localparam logic [3:0] SPSS_THR_PERIOD = 4'hf;
	localparam logic [3:0] SPSS_THR_ZERO = 4'h0;
	localparam logic [3:0] SPSS_THR_ONE = 4'h1;
	localparam logic [7:0] SPSS_CNT_ZERO = 8'h00;
	localparam logic [7:0] SPSS_CNT_ONE = 8'h01;
endpackage : spss_pkg

// File: src/spss_throttle.sv
// Stop-clock throttle generator for the running state
`timescale 1ns/10ps
`default_nettype none
module spss_throttle (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic enable_in,
	input wire logic [spss_pkg::SPSS_THR_W-1:0] duty_in,
	output logic stop_out
);
	import spss_pkg::*;
	typedef struct packed {
		logic [SPSS_THR_W-1:0] phase;
		logic stop;
	} spss_thr_t;
	spss_thr_t s_q, s_d;
	// Phase counter; stop is asserted while phase is below duty
	always_comb begin
		s_d = s_q;
		if (!enable_in) begin
			s_d.phase = SPSS_THR_ZERO;
			s_d.stop = 1'b0;
		end else begin
			s_d.phase = (s_q.phase == SPSS_THR_PERIOD) ? SPSS_THR_ZERO : s_q.phase + SPSS_THR_ONE;
			s_d.stop = (s_q.phase < duty_in);
		end
	end
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign stop_out = s_q.stop;
endmodule : spss_throttle
`default_nettype wire

// File: src/spss_wake_keep.sv
// Always-powered wake event keeper that survives power failure
`timescale 1ns/10ps
`default_nettype none
module spss_wake_keep (
	input wire logic mclk_in,
	input wire logic rtc_rst_in,
	input wire logic [3:0] wake_ev_in,
	input wire logic [3:0] keep_en_in,
	input wire logic clear_in,
	output logic [3:0] kept_out
);
	import spss_pkg::*;
	typedef struct packed {
		logic [3:0] kept;
	} spss_keep_t;
	spss_keep_t s_q, s_d;
	// Sticky capture; a new event wins over the clear
	always_comb begin
		s_d = s_q;
		if (clear_in) begin
			s_d.kept = 4'h0;
		end
		s_d.kept = s_d.kept | (wake_ev_in & keep_en_in);
	end
	// Of the resets, only the RTC-well reset clears this state
	always_ff @(posedge mclk_in) begin
		if (rtc_rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign kept_out = s_q.kept;
endmodule : spss_wake_keep
`default_nettype wire

// File: src/spss_sequencer.sv
// System power state sequencer: tracks sleep states and drives stop-clock and sleep
`timescale 1ns/10ps
`default_nettype none
module spss_sequencer (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic rtc_rst_in,
	input wire logic power_ok_in,
	input wire logic halt_in,
	input wire logic stop_grant_ack_in,
	input wire logic break_event_in,
	input wire logic [3:0] wake_event_in,
	input wire logic [3:0] wake_enable_in,
	input wire logic [3:0] wake_keep_in,
	input wire logic power_button_override_in,
	input wire logic sleep_request_enable,
	input wire logic [1:0] sleep_type_in,
	input wire logic cpu_sleep_enable_in,
	input wire logic throttle_enable_in,
	input wire logic [spss_pkg::SPSS_THR_W-1:0] throttle_duty_in,
	input wire logic thermal_alarm_in_n,
	input wire logic after_power_fail_select,
	output logic cpu_stop_clock_request_n,
	output logic cpu_sleep_out_n,
	output logic cpu_reset_out,
	output logic clocks_run_out,
	output logic [3:0] state_code_out,
	output logic [3:0] kept_wake_out
);
	import spss_pkg::*;
	typedef struct packed {
		spss_state_t st;
		logic [1:0] slp_type;
		logic [SPSS_CNT_W-1:0] cnt;
		logic ack_seen;
		logic was_off;
		logic cpu_stop_clock_request_n_n;
		logic cpu_sleep_out_n_n;
		logic cpu_rst;
		logic clk_run;
		logic [3:0] code;
		logic [3:0] kept;
	} spss_seq_t;
	spss_seq_t s_q, s_d;
	logic thr_stop;
	logic [3:0] kept_w;
	logic wake_any;
	logic keep_clear;
	logic thr_en;

	// Running-state throttle pulses
	spss_throttle u_throttle (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.enable_in(thr_en),
		.duty_in(throttle_duty_in),
		.stop_out(thr_stop)
	);

	// Wake indications held in the always-on well
	spss_wake_keep u_keep (
		.mclk_in(mclk_in),
		.rtc_rst_in(rtc_rst_in),
		.wake_ev_in(wake_event_in),
		.keep_en_in(wake_keep_in),
		.clear_in(keep_clear),
		.kept_out(kept_w)
	);

	// Throttle request source
	// Software or thermal start
	assign thr_en = (s_q.st == SPSS_C0) && (throttle_enable_in || !thermal_alarm_in_n);
	// A wake counts if enabled now, or kept through a power failure
	// Kept wake used
	assign wake_any = |(wake_event_in & wake_enable_in) || |kept_w;
	assign keep_clear = s_d.st == SPSS_C0 || s_d.st == SPSS_BOOT;

	// Code reported per settled state
	function automatic logic [3:0] spss_code(input spss_state_t st, input logic [3:0] cur);
		unique case (st)
			SPSS_C0: spss_code = SPSS_CODE_C0;
			SPSS_C1: spss_code = SPSS_CODE_C1;
			SPSS_S1: spss_code = SPSS_CODE_S1;
			SPSS_S3: spss_code = SPSS_CODE_S3;
			SPSS_S4: spss_code = SPSS_CODE_S4;
			SPSS_S5: spss_code = SPSS_CODE_S5;
			SPSS_G3: spss_code = SPSS_CODE_G3;
			SPSS_ENTER: spss_code = cur;
			SPSS_BOOT: spss_code = cur;
		endcase
	endfunction : spss_code

	// Next-state and output logic
	always_comb begin
		s_d = s_q;
		s_d.kept = kept_w;
		if (!power_ok_in) begin
			if (s_q.st != SPSS_G3) begin
				s_d.was_off = (s_q.st == SPSS_S5);
			end
			s_d.st = SPSS_G3;
		end else begin
			unique case (s_q.st)
				SPSS_C0: begin
					if (power_button_override_in) begin
						s_d.st = SPSS_S5;
					end else if (sleep_request_enable) begin
						s_d.slp_type = sleep_type_in;
						s_d.st = SPSS_ENTER;
						s_d.cnt = SPSS_CNT_ZERO;
						s_d.ack_seen = 1'b0;
					end else if (halt_in) begin
						s_d.st = SPSS_C1;
					end
				end
				SPSS_C1: begin
					if (power_button_override_in) begin
						s_d.st = SPSS_S5;
					end else if (sleep_request_enable) begin
						s_d.slp_type = sleep_type_in;
						s_d.st = SPSS_ENTER;
						s_d.cnt = SPSS_CNT_ZERO;
						s_d.ack_seen = 1'b0;
					end else if (break_event_in) begin
						s_d.st = SPSS_C0;
					end
				end
				SPSS_ENTER: begin
					if (power_button_override_in) begin
						s_d.st = SPSS_S5;
					end else if (stop_grant_ack_in || s_q.ack_seen) begin
						s_d.ack_seen = 1'b1;
						unique case (s_q.slp_type)
							SPSS_SLP_S1: s_d.st = SPSS_S1;
							SPSS_SLP_S3: s_d.st = SPSS_S3;
							SPSS_SLP_S4: s_d.st = SPSS_S4;
							SPSS_SLP_S5: s_d.st = SPSS_S5;
						endcase
					end
				end
				SPSS_S1, SPSS_S3, SPSS_S4: begin
					if (power_button_override_in) begin
						s_d.st = SPSS_S5;
					end else if (wake_any) begin
						s_d.st = (s_q.st == SPSS_S1) ? SPSS_C0 : SPSS_BOOT;
					end else if (s_q.cnt != SPSS_SLP_DLY) begin
						s_d.cnt = s_q.cnt + SPSS_CNT_ONE;
					end
				end
				SPSS_S5: begin
					if (wake_any) begin
						s_d.st = SPSS_BOOT;
					end
				end
				SPSS_G3: begin
					if (after_power_fail_select || s_q.was_off) begin
						s_d.st = SPSS_S5;
					end else begin
						s_d.st = SPSS_BOOT;
					end
				end
				SPSS_BOOT: begin
					s_d.st = SPSS_C0;
				end
			endcase
		end
		// Outputs follow the next state
		s_d.code = spss_code(s_d.st, s_q.code);
		s_d.cpu_stop_clock_request_n_n = !((s_d.st == SPSS_C0 && thr_stop) ||
			s_d.st == SPSS_ENTER || s_d.st == SPSS_S1);
		s_d.cpu_sleep_out_n_n = !(s_d.st == SPSS_S1 && cpu_sleep_enable_in &&
			s_q.st == SPSS_S1 && s_q.cnt == SPSS_SLP_DLY);
		// Clocks stop in S3 and deeper
		s_d.clk_run = !(s_d.st == SPSS_S3 || s_d.st == SPSS_S4 ||
			s_d.st == SPSS_S5 || s_d.st == SPSS_G3);
		s_d.cpu_rst = (s_d.st == SPSS_BOOT) || !s_d.clk_run;
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_q.st <= SPSS_C0;
			s_q.slp_type <= SPSS_SLP_S1;
			s_q.cnt <= SPSS_CNT_ZERO;
			s_q.ack_seen <= 1'b0;
			s_q.was_off <= 1'b0;
			s_q.cpu_stop_clock_request_n_n <= 1'b1;
			s_q.cpu_sleep_out_n_n <= 1'b1;
			s_q.cpu_rst <= 1'b0;
			s_q.clk_run <= 1'b1;
			s_q.code <= SPSS_CODE_C0;
			s_q.kept <= 4'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cpu_stop_clock_request_n = s_q.cpu_stop_clock_request_n_n;
	assign cpu_sleep_out_n = s_q.cpu_sleep_out_n_n;
	assign cpu_reset_out = s_q.cpu_rst;
	assign clocks_run_out = s_q.clk_run;
	assign state_code_out = s_q.code;
	assign kept_wake_out = s_q.kept;

	a_sleep_delay: assert property (@(posedge mclk_in) disable iff (srst_in)
		$fell(cpu_sleep_out_n) |-> $past(s_q.st, 2) == SPSS_S1 && $past(s_q.cnt, 1) == SPSS_SLP_DLY)
		else $error("processor sleep asserted early");
	a_sleep_option: assert property (@(posedge mclk_in) disable iff (srst_in)
		$fell(cpu_sleep_out_n) |-> $past(cpu_sleep_enable_in))
		else $error("processor sleep asserted while option off");
	a_s1_cpu_stop_clock_request_n: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.st == SPSS_S1 |-> !cpu_stop_clock_request_n)
		else $error("stop-clock not held in stop-grant");
	a_s3_clocks: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.st == SPSS_S3 |-> !clocks_run_out)
		else $error("clocks running in suspend-to-RAM");
	a_throttle_stays: assert property (@(posedge mclk_in) disable iff (srst_in)
		thr_en && power_ok_in && !power_button_override_in && !sleep_request_enable &&
		!halt_in |=> s_q.st == SPSS_C0)
		else $error("throttle left running state");
	a_thr_source: assert property (@(posedge mclk_in) disable iff (srst_in)
		$rose(thr_stop) |-> $past(s_q.st) == SPSS_C0 &&
		($past(throttle_enable_in) || $past(thermal_alarm_in_n) == 1'b0))
		else $error("throttle started without a source");
	a_sleep_entry: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_C0 && sleep_request_enable && !power_button_override_in
		|=> s_q.st == SPSS_ENTER && !cpu_stop_clock_request_n)
		else $error("sleep request not taken");
	a_enter_code: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.st == SPSS_ENTER |-> $stable(state_code_out))
		else $error("intermediate state reported");
	a_wake_s1: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_S1 && wake_any && !power_button_override_in
		|=> s_q.st == SPSS_C0 && cpu_stop_clock_request_n && cpu_sleep_out_n)
		else $error("stop-grant wake did not resume");
	a_power_loss: assert property (@(posedge mclk_in) disable iff (srst_in)
		!power_ok_in |=> s_q.st == SPSS_G3 ##0 state_code_out == SPSS_CODE_G3)
		else $error("power loss not handled");
	a_override_off: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && power_button_override_in &&
		s_q.st inside {SPSS_C0, SPSS_C1, SPSS_ENTER, SPSS_S1, SPSS_S3, SPSS_S4}
		|=> s_q.st == SPSS_S5)
		else $error("override did not force soft-off");
	a_halt_c1: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_C0 && halt_in && !sleep_request_enable &&
		!power_button_override_in |=> state_code_out == SPSS_CODE_C1)
		else $error("halt not recorded");
	a_break_c0: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_C1 && break_event_in && !sleep_request_enable &&
		!power_button_override_in |=> s_q.st == SPSS_C0)
		else $error("break did not return to running");
	a_s5_boot: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_S5 && wake_any |=> cpu_reset_out ##1 s_q.st == SPSS_C0)
		else $error("soft-off wake skipped reset");
	a_kept_wake: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_S5 && (|kept_w) |=> s_q.st == SPSS_BOOT)
		else $error("kept wake ignored");
	a_g3_return: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_G3 && after_power_fail_select |=> s_q.st == SPSS_S5)
		else $error("power return ignored after-fail bit");
	a_g3_reboot: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_ok_in && s_q.st == SPSS_G3 && !after_power_fail_select && !s_q.was_off
		|=> s_q.st == SPSS_BOOT && cpu_reset_out)
		else $error("power return did not reboot");
endmodule : spss_sequencer
`default_nettype wire

// File: testbench/spss_cpu_model.sv
// Processor model: acknowledges stop-clock requests and raises halt on command
`timescale 1ns/10ps
`default_nettype none
module spss_cpu_model (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic stop_req_n_in,
	input wire logic halt_cmd_in,
	output logic ack_out,
	output logic halt_out
);
	// One cycle late, as a real stop-grant cycle would be
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			ack_out <= 1'b0;
			halt_out <= 1'b0;
		end else begin
			ack_out <= ~stop_req_n_in;
			halt_out <= halt_cmd_in;
		end
	end
endmodule : spss_cpu_model
`default_nettype wire

// File: testbench/system_power_state_sequencer_bench.sv
// Self-checking bench for the power state sequencer
`timescale 1ns/10ps
`default_nettype none
module system_power_state_sequencer_bench;
	import spss_pkg::*;
	logic mclk_in = 1'b0, srst_in = 1'b1, power_ok_in = 1'b1, halt_cmd = 1'b0, halt_in, ack;
	logic break_event_in = 1'b0, pbo = 1'b0, sleep_request_enable = 1'b0, cpu_sleep_en = 1'b1;
	logic [3:0] wake_event_in = 4'h0, wake_enable_in = 4'hf, st, kept;
	logic [3:0] wake_keep = 4'h0;
	logic [1:0] sleep_type_in = 2'h0;
	logic thr_en = 1'b0, thermal_alarm_in_n = 1'b1, apf = 1'b0;
	logic stop_n, sleep_n, rst_o, clk_run;
	int n_mismatch = 0, checked = 0;
	// Clock at 125 MHz
	always #4 mclk_in = ~mclk_in;
	spss_sequencer spss_sequencer_inst (.mclk_in(mclk_in), .srst_in(srst_in),
		.rtc_rst_in(srst_in), .power_ok_in(power_ok_in), .halt_in(halt_in),
		.stop_grant_ack_in(ack), .break_event_in(break_event_in),
		.wake_event_in(wake_event_in), .wake_enable_in(wake_enable_in),
		.wake_keep_in(wake_keep), .power_button_override_in(pbo),
		.sleep_request_enable(sleep_request_enable), .sleep_type_in(sleep_type_in),
		.cpu_sleep_enable_in(cpu_sleep_en), .throttle_enable_in(thr_en),
		.throttle_duty_in(4'h4), .thermal_alarm_in_n(thermal_alarm_in_n),
		.after_power_fail_select(apf), .cpu_stop_clock_request_n(stop_n),
		.cpu_sleep_out_n(sleep_n), .cpu_reset_out(rst_o), .clocks_run_out(clk_run),
		.state_code_out(st), .kept_wake_out(kept));
	spss_cpu_model spss_cpu_model_inst (.mclk_in(mclk_in), .srst_in(srst_in),
		.stop_req_n_in(stop_n), .halt_cmd_in(halt_cmd), .ack_out(ack), .halt_out(halt_in));
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	// Compare one observed value against its expectation
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Bounded wait for a reported state
	task automatic wait_code(input logic [3:0] c);
		int i;
		i = 0;
		while (st !== c && i < 400) begin
			@(negedge mclk_in);
			i++;
		end
		chk("state code", 8'(st), 8'(c));
		if (i >= 400) report_and_stop();
	endtask : wait_code
	task automatic pulse_wake();
		wake_event_in = 4'h1;
		@(negedge mclk_in);
		wake_event_in = 4'h0;
	endtask : pulse_wake
	task automatic req_sleep(input logic [1:0] t);
		sleep_type_in = t;
		sleep_request_enable = 1'b1;
		@(negedge mclk_in);
		sleep_request_enable = 1'b0;
	endtask : req_sleep
	task automatic t_reset();
		chk("reset outputs", {stop_n, sleep_n, rst_o, clk_run, st}, 8'hd0);
	endtask : t_reset
	// Both throttle sources give the programmed duty, then it stops
	task automatic t_throttle();
		int lows;
		for (int m = 0; m < 2; m++) begin
			thr_en = m[0];
			thermal_alarm_in_n = m[0];
			repeat (16) @(negedge mclk_in);
			lows = 0;
			repeat (32) begin
				@(negedge mclk_in);
				lows += int'(!stop_n);
			end
			chk("throttle low cycles", 8'(lows), 8'h08);
			chk("state during throttle", 8'(st), 8'(SPSS_CODE_C0));
		end
		thr_en = 1'b0;
		repeat (20) @(negedge mclk_in);
		chk("stop-clock idle", 8'(stop_n), 8'h01);
	endtask : t_throttle
	task automatic t_halt();
		halt_cmd = 1'b1;
		wait_code(SPSS_CODE_C1);
		halt_cmd = 1'b0;
		break_event_in = 1'b1;
		wait_code(SPSS_CODE_C0);
		break_event_in = 1'b0;
	endtask : t_halt
	// Stop-grant with processor sleep after the least delay, then once with the option off
	task automatic t_stop_grant();
		int n;
		req_sleep(SPSS_SLP_S1);
		wait_code(SPSS_CODE_S1);
		chk("stop-clock held", 8'(stop_n), 8'h00);
		n = 0;
		while (sleep_n !== 1'b0 && n < 400) begin
			@(negedge mclk_in);
			n++;
		end
		chk("sleep delay long enough", 8'(n >= int'(SPSS_SLP_DLY) - 1), 8'h01);
		chk("sleep asserted", 8'(sleep_n), 8'h00);
		if (n >= 400) report_and_stop();
		pulse_wake();
		wait_code(SPSS_CODE_C0);
		chk("signals released", 8'({stop_n, sleep_n}), 8'h03);
		cpu_sleep_en = 1'b0;
		req_sleep(SPSS_SLP_S1);
		wait_code(SPSS_CODE_S1);
		repeat (240) @(negedge mclk_in);
		chk("sleep option off", 8'({stop_n, sleep_n}), 8'h01);
		pulse_wake();
		wait_code(SPSS_CODE_C0);
		cpu_sleep_en = 1'b1;
	endtask : t_stop_grant
	// Suspend-to-RAM stops clocks; wake passes through processor reset
	task automatic t_suspend_ram();
		req_sleep(SPSS_SLP_S3);
		wait_code(SPSS_CODE_S3);
		chk("clocks stopped", 8'(clk_run), 8'h00);
		pulse_wake();
		chk("boot reset", 8'(rst_o), 8'h01);
		wait_code(SPSS_CODE_C0);
		chk("clocks running", 8'({clk_run, rst_o}), 8'h02);
	endtask : t_suspend_ram
	// Override, power loss and the two ways back; soft-off before the loss keeps soft-off
	task automatic t_power();
		req_sleep(SPSS_SLP_S4);
		wait_code(SPSS_CODE_S4);
		pbo = 1'b1;
		wait_code(SPSS_CODE_S5);
		pbo = 1'b0;
		power_ok_in = 1'b0;
		wait_code(SPSS_CODE_G3);
		power_ok_in = 1'b1;
		wait_code(SPSS_CODE_S5);
		pulse_wake();
		chk("boot from soft-off", 8'(rst_o), 8'h01);
		wait_code(SPSS_CODE_C0);
		power_ok_in = 1'b0;
		wait_code(SPSS_CODE_G3);
		power_ok_in = 1'b1;
		wait_code(SPSS_CODE_C0);
	endtask : t_power
	// After-fail bit keeps soft-off from running; a kept wake outlives the power loss
	task automatic t_keep();
		apf = 1'b1;
		power_ok_in = 1'b0;
		wait_code(SPSS_CODE_G3);
		power_ok_in = 1'b1;
		wait_code(SPSS_CODE_S5);
		repeat (8) @(negedge mclk_in);
		chk("stays soft-off", 8'(st), 8'(SPSS_CODE_S5));
		wake_keep = 4'h2;
		power_ok_in = 1'b0;
		wait_code(SPSS_CODE_G3);
		wake_event_in = 4'h2;
		@(negedge mclk_in);
		wake_event_in = 4'h0;
		repeat (2) @(negedge mclk_in);
		chk("wake kept without power", 8'(kept), 8'h02);
		power_ok_in = 1'b1;
		wait_code(SPSS_CODE_C0);
		chk("kept wake cleared", 8'(kept), 8'h00);
		apf = 1'b0;
		wake_keep = 4'h0;
	endtask : t_keep
	// Main sequence
	initial begin
		repeat (20) @(negedge mclk_in);
		srst_in = 1'b0;
		@(negedge mclk_in);
		t_reset();
		t_throttle();
		t_halt();
		t_stop_grant();
		t_suspend_ram();
		t_power();
		t_keep();
		report_and_stop();
	end
endmodule : system_power_state_sequencer_bench
`default_nettype wire
